// ==== common/sdmb_pkg.sv ====
// Purpose: Shared constants, command codes and carriers for the SDRAM command front end.
// Assumes: 16-bit data organization, four banks, one 20 MHz clock.
// Notes: Field positions follow the mode word layout on the address and bank inputs.
`default_nettype none
package sdmb_pkg;
  localparam int ROW_W = 13;
  localparam int COL_W = 10;
  localparam int BANK_W = 2;
  localparam int NBANK = 4;
  localparam int DQ_W = 16;
  localparam int MODE_W = 14;
  localparam int FIFO_DEPTH = 16;
  localparam int RD_PIPE = 3;
  // Mode word fields.
  localparam int BL_LSB = 0;
  localparam int BO_BIT = 3;
  localparam int RL_LSB = 4;
  localparam int OPM_LSB = 7;
  localparam int WS_BIT = 9;
  localparam int RSEL_LSB = 12;
  localparam int PSCOPE_BIT = 10;
  // The real part powers up unknown; reset gives latency 2 and single-beat bursts.
  localparam logic [MODE_W-1:0] MODE_RESET = 14'h0020;
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] RL_3 = 3'h3;
  localparam logic [1:0] RSEL_MAIN = 2'h0;
  localparam logic [COL_W-1:0] COL_ONE = 10'h001;
  localparam logic [COL_W-1:0] COL_ZERO = 10'h000;
  typedef enum logic [2:0] {
    CMD_LMR = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR = 3'h4,
    CMD_RD = 3'h5,
    CMD_BST = 3'h6,
    CMD_NOP = 3'h7
  } sdmb_cmd_t;
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic bank_select_high;
    logic bank_select_low;
    logic [ROW_W-1:0] addr;
    logic dqm;
    logic [DQ_W-1:0] dq;
  } sdmb_pins_t;
  typedef struct packed {
    logic write;
    logic mask;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic [DQ_W-1:0] data;
  } sdmb_access_t;
  localparam int ACC_W = $bits(sdmb_access_t);
endpackage : sdmb_pkg
`default_nettype wire

// ==== rtl/sdmb_fifo.sv ====
// Purpose: Synchronous FIFO carrying column accesses toward the array.
// Assumes: One clock, synchronous active-high reset.
// Notes: Full and empty come from an occupancy count, so both are exact.
`default_nettype none
module sdmb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  always_comb begin
    in_ready_o = (count != DEPTH[AW:0]);
    out_valid_o = (count != '0);
    out_data_o = mem[rd_ptr];
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end
endmodule : sdmb_fifo
`default_nettype wire

// ==== rtl/sdmb_core.sv ====
// Purpose: Device-side command decoder, mode storage, bank tracking and burst generator.
// Assumes: Controller inputs are synchronous to clk_i; the array drains acc_o.
// Notes: Each burst beat becomes one access record; reads return on dq_o by latency.
// Operation
// - All inputs sampled on rising clock edge.
// - ACTIVE latches bank select and row address.
// - READ/WRITE start column from low address bits.
// - Mode registers loaded before operational commands.
// - Mode word kept until rewritten.
// - Mode word decoded into five fields; the core decodes four, and the operating mode bits at OPM_LSB are not used.
// - Burst length limits column accesses per command.
// - Sequential full-page burst ends by terminate.
// - Burst wraps inside aligned length block.
// - Mode bit three selects interleaved order.
// - Order depends on length, type, start.
// - Read latency two or three clocks.
// - Write single bit forces one-location writes.
// - Address bit ten selects precharge scope.
`default_nettype none
module sdmb_core
  import sdmb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sdmb_pkg::sdmb_pins_t pins_i,
  output logic [sdmb_pkg::DQ_W-1:0] dq_o,
  output logic dq_oe_o,
  output sdmb_pkg::sdmb_access_t acc_o,
  output logic acc_valid_o,
  input wire logic acc_ready_i,
  input wire logic [sdmb_pkg::DQ_W-1:0] rdata_i,
  output logic [sdmb_pkg::MODE_W-1:0] mode_o,
  output logic all_idle_o
);
  import sdmb_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BURST = 2'b10
  } sdmb_state_t;

  sdmb_state_t state, next_state;
  sdmb_cmd_t cmd;
  logic [MODE_W-1:0] operating_mode_settings, next_mode;
  logic [NBANK-1:0] open, next_open;
  logic [ROW_W-1:0] open_row [NBANK];
  logic [ROW_W-1:0] next_row [NBANK];
  logic [COL_W-1:0] cnt, next_cnt, start, next_start, cur_mask, new_mask;
  logic [2:0] blen, next_blen;
  logic [BANK_W-1:0] bank, next_bank, pin_bank;
  logic wr, next_wr, ap, next_ap, il, next_il;
  logic [RD_PIPE-1:0] rd_pipe, next_rd_pipe, msk_pipe, next_msk_pipe;
  logic [DQ_W-1:0] next_dq;
  logic rw_cmd, beat_valid, accept, in_ready, rl3, new_last, cur_last;
  logic [2:0] new_bl;
  sdmb_access_t beat;

  function automatic logic [COL_W-1:0] bl_mask(input logic [2:0] code);
    logic [COL_W-1:0] m;
    m = COL_ZERO;
    unique case (code)
      BL_2: m = 10'h001;
      BL_4: m = 10'h003;
      BL_8: m = 10'h007;
      BL_FULL: m = 10'h3ff;
      default: m = COL_ZERO;
    endcase
    return m;
  endfunction : bl_mask

  // Low bits walk inside the block; upper bits stay put, which gives the wrap.
  function automatic logic [COL_W-1:0] beat_col(input logic [COL_W-1:0] s,
      input logic [COL_W-1:0] n, input logic [COL_W-1:0] m, input logic inter);
    logic [COL_W-1:0] low;
    low = inter ? ((s ^ n) & m) : ((s + n) & m);
    return (s & ~m) | low;
  endfunction : beat_col

  always_comb begin
    cmd = (pins_i.cke && !pins_i.cs_n) ?
        sdmb_cmd_t'({pins_i.ras_n, pins_i.cas_n, pins_i.we_n}) : CMD_NOP;
    pin_bank = {pins_i.bank_select_high, pins_i.bank_select_low};
    rw_cmd = (cmd == CMD_RD) || (cmd == CMD_WR);
    rl3 = (operating_mode_settings[RL_LSB +: 3] == RL_3);
    // Continuous page is sequential only; interleave is ignored there.
    new_bl = operating_mode_settings[BL_LSB +: 3];
    if ((cmd == CMD_WR) && operating_mode_settings[WS_BIT]) begin
      new_bl = BL_1;
    end
    new_mask = bl_mask(new_bl);
    cur_mask = bl_mask(blen);
    new_last = (new_mask == COL_ZERO);
    cur_last = (cnt == cur_mask) && (blen != BL_FULL);
    beat = '0;
    beat_valid = 1'b0;
    if (rw_cmd) begin
      beat_valid = 1'b1;
      beat.write = (cmd == CMD_WR);
      beat.bank = pin_bank;
      beat.row = open_row[pin_bank];
      beat.col = pins_i.addr[COL_W-1:0];
    end else if (state == ST_BURST) begin
      beat_valid = 1'b1;
      beat.write = wr;
      beat.bank = bank;
      beat.row = open_row[bank];
      beat.col = beat_col(start, cnt, cur_mask, il && (blen != BL_FULL));
    end
    beat.mask = pins_i.dqm;
    beat.data = pins_i.dq;
    accept = beat_valid && in_ready;
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_start = start;
    next_blen = blen;
    next_bank = bank;
    next_wr = wr;
    next_ap = ap;
    next_il = il;
    next_open = open;
    next_mode = operating_mode_settings;
    for (int b = 0; b < NBANK; b++) begin
      next_row[b] = open_row[b];
    end
    unique case (cmd)
      CMD_ACT: begin
        next_open[pin_bank] = 1'b1;
        next_row[pin_bank] = pins_i.addr;
      end
      CMD_PRE: begin
        if (pins_i.addr[PSCOPE_BIT]) begin
          next_open = '0;
        end else begin
          next_open[pin_bank] = 1'b0;
        end
        next_state = ST_IDLE;
      end
      CMD_BST: next_state = ST_IDLE;
      CMD_LMR: begin
        // The extended register select is not kept here; only the main word is.
        if (pin_bank == RSEL_MAIN) begin
          next_mode = {pin_bank, pins_i.addr[RSEL_LSB-1:0]};
        end
      end
      CMD_RD, CMD_WR: begin
        next_start = pins_i.addr[COL_W-1:0];
        next_blen = new_bl;
        next_bank = pin_bank;
        next_wr = (cmd == CMD_WR);
        next_ap = pins_i.addr[PSCOPE_BIT];
        next_il = operating_mode_settings[BO_BIT];
        next_cnt = accept ? COL_ONE : COL_ZERO;
        next_state = (accept && new_last) ? ST_IDLE : ST_BURST;
        if (accept && new_last && pins_i.addr[PSCOPE_BIT]) begin
          next_open[pin_bank] = 1'b0;
        end
      end
      default: begin
        if ((state == ST_BURST) && accept) begin
          if (cur_last) begin
            next_state = ST_IDLE;
            if (ap) begin
              next_open[bank] = 1'b0;
            end
          end else begin
            next_cnt = cnt + COL_ONE;
          end
        end
      end
    endcase
  end

  // Read beats ride a latency pipe; dqm at the beat masks the drive.
  always_comb begin
    next_rd_pipe = {rd_pipe[RD_PIPE-2:0], accept && !beat.write};
    next_msk_pipe = {msk_pipe[RD_PIPE-2:0], beat.mask};
    next_dq = dq_o;
    if (rl3 ? rd_pipe[1] : rd_pipe[0]) begin
      next_dq = rdata_i;
    end
    dq_oe_o = rl3 ? (rd_pipe[2] && !msk_pipe[2]) : (rd_pipe[1] && !msk_pipe[1]);
    mode_o = operating_mode_settings;
    all_idle_o = (open == '0);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      cnt <= COL_ZERO;
      start <= COL_ZERO;
      blen <= BL_1;
      bank <= '0;
      wr <= 1'b0;
      ap <= 1'b0;
      il <= 1'b0;
      open <= '0;
      operating_mode_settings <= MODE_RESET;
      rd_pipe <= '0;
      msk_pipe <= '0;
      dq_o <= '0;
      for (int b = 0; b < NBANK; b++) begin
        open_row[b] <= '0;
      end
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      start <= next_start;
      blen <= next_blen;
      bank <= next_bank;
      wr <= next_wr;
      ap <= next_ap;
      il <= next_il;
      open <= next_open;
      operating_mode_settings <= next_mode;
      rd_pipe <= next_rd_pipe;
      msk_pipe <= next_msk_pipe;
      dq_o <= next_dq;
      for (int b = 0; b < NBANK; b++) begin
        open_row[b] <= next_row[b];
      end
    end
  end

  // A full FIFO stalls the burst counter, so the array can apply back-pressure.
  sdmb_fifo #(
    .WIDTH(ACC_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(beat_valid),
    .in_ready_o(in_ready),
    .in_data_i(beat),
    .out_valid_o(acc_valid_o),
    .out_ready_i(acc_ready_i),
    .out_data_o(acc_o)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_act_opens_bank: assert property (cmd == CMD_ACT |=> open[$past(pin_bank)])
    else $error("bank not open after activate");
  a_act_row_latch: assert property (cmd == CMD_ACT |=> open_row[$past(pin_bank)] == $past(pins_i.addr))
    else $error("row not latched on activate");
  a_first_col_pass: assert property (rw_cmd |-> beat.col == pins_i.addr[COL_W-1:0])
    else $error("first beat column differs from address");
  a_mode_held: assert property (cmd != CMD_LMR |=> $stable(operating_mode_settings))
    else $error("mode word changed without load");
  a_bl4_block_wrap: assert property (state == ST_BURST && blen == BL_4 && !rw_cmd
      |-> beat.col[COL_W-1:2] == start[COL_W-1:2])
    else $error("burst left its block");
  a_il8_second: assert property (state == ST_BURST && !rw_cmd && blen == BL_8 && il && cnt == COL_ONE
      |-> beat.col[2:0] == {start[2:1], ~start[0]})
    else $error("interleaved order wrong");
  a_burst_len_end: assert property (state == ST_BURST && accept && cmd == CMD_NOP && cur_last
      |=> state == ST_IDLE)
    else $error("burst did not end at its length");
  a_full_page_run: assert property (state == ST_BURST && blen == BL_FULL && cmd == CMD_NOP
      |=> state == ST_BURST)
    else $error("full page burst ended without terminate");
  a_write_single: assert property (cmd == CMD_WR && accept && operating_mode_settings[WS_BIT]
      ##1 cmd == CMD_NOP |-> state == ST_IDLE)
    else $error("write burst not single");
  a_lat2_drive: assert property (accept && !beat.write && !beat.mask && !rl3 && cmd == CMD_RD
      ##1 (!rl3 && cmd != CMD_LMR) [*2] |-> dq_oe_o)
    else $error("latency two drive missing");
  a_lat3_drive: assert property (accept && !beat.write && !beat.mask && rl3 && cmd == CMD_RD
      ##1 (rl3 && cmd != CMD_LMR) [*3] |-> dq_oe_o)
    else $error("latency three drive missing");
  a_pre_all_close: assert property (cmd == CMD_PRE && pins_i.addr[PSCOPE_BIT] |=> all_idle_o)
    else $error("all-bank precharge left a bank open");

  c_read_bl8: cover property (cmd == CMD_RD && new_bl == BL_8);
  c_write_single: cover property (cmd == CMD_WR && operating_mode_settings[WS_BIT]);
  c_full_term: cover property (state == ST_BURST && blen == BL_FULL ##1 cmd == CMD_BST);
  c_mode_load: cover property (cmd == CMD_LMR && pin_bank == RSEL_MAIN);
endmodule : sdmb_core
`default_nettype wire

// ==== testbench/sdmb_ctl.sv ====
// Purpose: Controller model driving the device command pins.
// Assumes: Pins change 1 ns after a rising edge of the 50 ns clock.
// Notes: Idle data lines flip every cycle, so a stale value never looks valid.
`default_nettype none
module sdmb_ctl
  import sdmb_pkg::*;
#(
  parameter int INIT_CYC = 2000
) (
  input wire logic clk_i,
  output var sdmb_pkg::sdmb_pins_t pins_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // The bench raises this to mask read drive; it rides along with every command.
  logic dqm_v = 1'b0;

  task automatic put(input sdmb_cmd_t c, input logic [1:0] b, input logic [ROW_W-1:0] a,
                     input logic [DQ_W-1:0] d);
    pins_o = {1'b1, 1'b0, c, b, a, dqm_v, d};
  endtask : put

  initial put(CMD_NOP, 2'h0, 13'h0000, 16'h0000);

  // A command stands for one edge and is then replaced by a no-operation.
  task automatic cmd(input sdmb_cmd_t c, input logic [1:0] b, input logic [ROW_W-1:0] a,
                     input logic [DQ_W-1:0] d);
    @(posedge clk_i);
    #1;
    put(c, b, a, d);
    @(posedge clk_i);
    #1;
    put(CMD_NOP, b, a, ~d);
  endtask : cmd

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_i);
      #1;
      put(CMD_NOP, 2'h0, pins_o.addr, ~pins_o.dq);
    end
  endtask : idle

  // Every load closes all banks first and lets the new word settle afterwards.
  task automatic load(input logic [ROW_W-1:0] mw);
    cmd(CMD_PRE, 2'h0, 13'h0400, 16'h0000);
    cmd(CMD_LMR, 2'h0, mw & 13'h027f, 16'h0000);
    idle(2);
  endtask : load

  task automatic init_seq(input logic [ROW_W-1:0] mw);
    idle(INIT_CYC);
    cmd(CMD_PRE, 2'h0, 13'h0400, 16'h0000);
    repeat (2) cmd(CMD_REF, 2'h0, 13'h0000, 16'h0000);
    load(mw);
  endtask : init_seq
endmodule : sdmb_ctl
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench for the device command front end.
// Assumes: 50 ns clock, inputs change 1 ns after each rising edge.
// Notes: The array side stalls at random, so beats are compared in order only.
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import sdmb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  sdmb_pins_t pins;
  logic [DQ_W-1:0] dq;
  logic dq_oe;
  sdmb_access_t acc;
  logic acc_vld;
  logic acc_rdy = 1'b0;
  logic [DQ_W-1:0] rdata = 16'h0000;
  logic [MODE_W-1:0] mode;
  logic all_idle;
  int fail_count = 0;
  int n_checks = 0;
  integer seed = 32'h2806e13b;
  int rdy_mode = 0;
  sdmb_access_t q[$];

  sdmb_core sdmb_core_i (.clk_i(clk), .rst_i(rst), .pins_i(pins), .dq_o(dq), .dq_oe_o(dq_oe),
    .acc_o(acc), .acc_valid_o(acc_vld), .acc_ready_i(acc_rdy), .rdata_i(rdata),
    .mode_o(mode), .all_idle_o(all_idle));
  sdmb_ctl #(.INIT_CYC(2000)) sdmb_ctl_i (.clk_i(clk), .pins_o(pins));

  initial forever #25 clk = ~clk;

  // Mode 0 stalls at random, 1 stalls always, 2 never stalls.
  always @(posedge clk) begin
    #1;
    acc_rdy = (rdy_mode == 0) ? 1'($random(seed)) : (rdy_mode == 2);
  end

  always @(posedge clk) if (!rst && acc_vld === 1'b1 && acc_rdy) q.push_back(acc);

  function automatic logic [ROW_W-1:0] mk_mode(input logic [2:0] bl, input logic bo,
                                               input logic [2:0] rl, input logic ws);
    return {3'h0, ws, 2'h0, rl, bo, bl};
  endfunction : mk_mode

  function automatic logic [COL_W-1:0] exp_col(input logic [COL_W-1:0] s, input logic [2:0] bl,
                                               input logic bo, input int k);
    logic [COL_W-1:0] m;
    m = (bl == BL_FULL) ? 10'h3ff : COL_W'((1 << bl) - 1);
    return (s & ~m) | ((bo ? (s ^ COL_W'(k)) : (s + COL_W'(k))) & m);
  endfunction : exp_col

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic burst(input logic [2:0] bl, input logic bo, input logic ws, input logic wr,
                       input logic [COL_W-1:0] c);
    logic [1:0] ba;
    logic [ROW_W-1:0] row;
    logic [DQ_W-1:0] d;
    int n;
    ba = 2'($random(seed));
    row = 13'($random(seed));
    d = 16'($random(seed));
    n = (wr && ws) ? 1 : (1 << bl);
    sdmb_ctl_i.load(mk_mode(bl, bo, 3'h2, ws));
    `CHK("mode", {1'b0, mk_mode(bl, bo, 3'h2, ws)}, mode)
    q.delete();
    sdmb_ctl_i.cmd(CMD_ACT, ba, row, d);
    sdmb_ctl_i.cmd(wr ? CMD_WR : CMD_RD, ba, {3'h0, c}, d);
    sdmb_ctl_i.idle(40);
    `CHK("beats", n, q.size())
    for (int k = 0; k < q.size(); k++) begin
      `CHK("col", exp_col(c, bl, bo, k), q[k].col)
      `CHK("bank_row", {ba, row}, {q[k].bank, q[k].row})
    end
    `CHK("beat0", {wr, d}, {q[0].write, q[0].data})
  endtask : burst

  initial begin
    #(30000 * 50);
    fail_count++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    `CHK("reset", {MODE_RESET, 3'h4}, {mode, all_idle, acc_vld, dq_oe})
    sdmb_ctl_i.init_seq(mk_mode(BL_2, 1'b0, 3'h2, 1'b0));
    sdmb_ctl_i.cmd(CMD_LMR, 2'h2, 13'h0055, 16'h0000);
    `CHK("ext_load", {1'b0, mk_mode(BL_2, 1'b0, 3'h2, 1'b0)}, mode)
    for (int b = 0; b < 4; b++) begin
      for (int t = 0; t < 4; t++) burst(3'(b), t[0], 1'b0, t[1], 10'($random(seed)));
    end
    burst(BL_8, 1'b1, 1'b0, 1'b0, 10'h3ff);
    burst(BL_8, 1'b0, 1'b1, 1'b1, 10'h005);
    burst(BL_8, 1'b0, 1'b1, 1'b0, 10'h005);
    sdmb_ctl_i.cmd(CMD_PRE, 2'h0, 13'h0400, 16'h0000);
    sdmb_ctl_i.cmd(CMD_ACT, 2'h1, 13'h0011, 16'h0000);
    sdmb_ctl_i.cmd(CMD_ACT, 2'h2, 13'h0022, 16'h0000);
    sdmb_ctl_i.cmd(CMD_PRE, 2'h1, 13'h0000, 16'h0000);
    `CHK("one_bank", 1'b0, all_idle)
    sdmb_ctl_i.cmd(CMD_PRE, 2'h2, 13'h0000, 16'h0000);
    `CHK("last_bank", 1'b1, all_idle)
    sdmb_ctl_i.cmd(CMD_ACT, 2'h3, 13'h0033, 16'h0000);
    sdmb_ctl_i.cmd(CMD_WR, 2'h3, 13'h0404, 16'h1234);
    sdmb_ctl_i.idle(12);
    `CHK("auto_pre", 1'b1, all_idle)
    rdy_mode = 2;
    for (int l = 2; l < 4; l++) begin
      sdmb_ctl_i.load(mk_mode(BL_1, 1'b0, 3'(l), 1'b0));
      sdmb_ctl_i.cmd(CMD_ACT, 2'h0, 13'h0100, 16'h0000);
      rdata = 16'($random(seed));
      sdmb_ctl_i.cmd(CMD_RD, 2'h0, 13'h0008, 16'h0000);
      `CHK("oe_early", 1'b0, dq_oe)
      repeat (l - 2) begin
        @(posedge clk);
        #1;
        `CHK("oe_wait", 1'b0, dq_oe)
      end
      @(posedge clk);
      #1;
      `CHK("rd_data", {1'b1, rdata}, {dq_oe, dq})
    end
    sdmb_ctl_i.dqm_v = 1'b1;
    sdmb_ctl_i.cmd(CMD_RD, 2'h0, 13'h0009, 16'h0000);
    repeat (3) begin
      @(posedge clk);
      #1;
      `CHK("oe_masked", 1'b0, dq_oe)
    end
    sdmb_ctl_i.dqm_v = 1'b0;
    sdmb_ctl_i.load(mk_mode(BL_FULL, 1'b0, 3'h2, 1'b0));
    sdmb_ctl_i.cmd(CMD_ACT, 2'h1, 13'h0abc, 16'h0000);
    rdy_mode = 1;
    sdmb_ctl_i.idle(2);
    q.delete();
    sdmb_ctl_i.cmd(CMD_RD, 2'h1, 13'h03fa, 16'h0000);
    sdmb_ctl_i.idle(30);
    `CHK("held", {1'b1, 32'd0}, {acc_vld, q.size()})
    sdmb_ctl_i.cmd(CMD_BST, 2'h1, 13'h0000, 16'h0000);
    rdy_mode = 2;
    sdmb_ctl_i.idle(30);
    `CHK("fifo_depth", FIFO_DEPTH, q.size())
    for (int k = 0; k < q.size(); k++) begin
      `CHK("page_col", exp_col(10'h3fa, BL_FULL, 1'b0, k), q[k].col)
    end
    `CHK("mode_kept", {1'b0, mk_mode(BL_FULL, 1'b0, 3'h2, 1'b0)}, mode)
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
